// ---- core/i2cam_pkg.sv ----
`default_nettype none
package i2cam_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_MASK = 4'h0;
  localparam logic [3:0] OFS_OWN = 4'h1;
  localparam logic [3:0] OFS_CTRL = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int MASK_W = 10;
  localparam int REG_W = 16;
  localparam int CTRL_SLAVE_BIT = 0;
  localparam int CTRL_TEN_BIT = 1;
  localparam int STAT_MATCH_BIT = 0;
  localparam logic [9:0] MASK_RST = 10'h000;
  localparam logic [9:0] OWN_RST = 10'h000;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // ----------------------------------------
  // Control field and compare widths
  // ----------------------------------------
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [9:0] WIDTH_TEN = 10'h3ff;
  localparam logic [9:0] WIDTH_SEVEN = 10'h07f;
endpackage
`default_nettype wire

// ---- core/i2cam_core.sv ----
// Summary of operation
// - Mask used only in slave address compare
// - Ten mask bits align with address bits
// - Set mask bit ignores that address bit
// - Clear mask bit requires exact bit match within the compared width
// - Mask bits fifteen to ten read zero
//
// The address map and strobed register access were decided locally.
`default_nettype none
module i2cam_core #(
  parameter int ADDR_W = i2cam_pkg::ADDR_W,
  parameter int REG_W = i2cam_pkg::REG_W,
  parameter int MASK_W = i2cam_pkg::MASK_W
) (
  input wire logic refClk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [REG_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_W-1:0] regRdData,
  input wire logic addrValid,
  input wire logic [MASK_W-1:0] rxAddr,
  output logic addrMatch,
  output logic matchValid
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Index compare shared by write decode and readback select
  function automatic logic isReg(
    input logic [ADDR_W-1:0] idx,
    input logic [3:0] ofs
  );
    isReg = (idx == ADDR_W'(ofs));
  endfunction

  // Field placed in low bits, upper bits forced to zero
  // Keeps unimplemented bits reading zero without extra muxing
  function automatic logic [REG_W-1:0] toWord(
    input logic [MASK_W-1:0] field
  );
    logic [REG_W-1:0] word;
    word = REG_W'(i2cam_pkg::READ_ZERO);
    word[MASK_W-1:0] = field;
    toWord = word;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------

  // Mask and own address kept apart so software can range-select
  logic [MASK_W-1:0] maskFf;
  logic [MASK_W-1:0] ownFf;
  logic [i2cam_pkg::CTRL_W-1:0] ctrlFf;
  logic matchStickyFf;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------

  // One select per register, reused for writes and reads
  wire logic selMask = isReg(regAddr, i2cam_pkg::OFS_MASK);
  wire logic selOwn = isReg(regAddr, i2cam_pkg::OFS_OWN);
  wire logic selCtrl = isReg(regAddr, i2cam_pkg::OFS_CTRL);
  wire logic selStat = isReg(regAddr, i2cam_pkg::OFS_STAT);

  // Write strobes; unmapped indices fall through and are ignored
  wire logic wrMask = regWr && selMask;
  wire logic wrOwn = regWr && selOwn;
  wire logic wrCtrl = regWr && selCtrl;
  wire logic wrStat = regWr && selStat;

  // Control fields
  wire logic slaveMode = ctrlFf[i2cam_pkg::CTRL_SLAVE_BIT];
  wire logic tenBit = ctrlFf[i2cam_pkg::CTRL_TEN_BIT];

  // ----------------------------------------
  // Address compare
  // ----------------------------------------

  // Seven-bit mode compares low seven bits only
  wire logic [MASK_W-1:0] widthTen = MASK_W'(i2cam_pkg::WIDTH_TEN);
  wire logic [MASK_W-1:0] widthSeven = MASK_W'(i2cam_pkg::WIDTH_SEVEN);
  wire logic [MASK_W-1:0] widthSel = tenBit ? widthTen : widthSeven;

  // Masked bits dropped from compare; unmasked must equal own address
  wire logic [MASK_W-1:0] careBits = ~maskFf & widthSel;

  // Per-bit verdict; a bit outside the care set always passes
  logic [MASK_W-1:0] bitOk;
  for (genvar g = 0; g < MASK_W; g++) begin : gBit
    assign bitOk[g] = !careBits[g] || (rxAddr[g] == ownFf[g]);
  end

  // All positions must pass for a hit
  wire logic hit = &bitOk;

  // Outside slave mode nothing is matched, mask irrelevant
  wire logic nxtMatch = addrValid && slaveMode && hit;

  // Sticky flag: a new hit beats a software clear in the same cycle
  wire logic nxtSticky = nxtMatch || (matchStickyFf && !wrStat);

  // ----------------------------------------
  // Readback select
  // ----------------------------------------

  // Unused upper bits come back zero through toWord
  wire logic [REG_W-1:0] rdMask = toWord(maskFf);
  wire logic [REG_W-1:0] rdOwn = toWord(ownFf);
  wire logic [REG_W-1:0] rdCtrl = toWord(MASK_W'(ctrlFf));
  wire logic [REG_W-1:0] rdStat = toWord(MASK_W'(matchStickyFf));
  wire logic [REG_W-1:0] rdZero = REG_W'(i2cam_pkg::READ_ZERO);

  // Priority order does not matter: selects are exclusive
  wire logic [REG_W-1:0] nxtRd =
    selMask ? rdMask :
    selOwn ? rdOwn :
    selCtrl ? rdCtrl :
    selStat ? rdStat :
    rdZero;

  // Bus shows zero outside the answer cycle
  wire logic [REG_W-1:0] nxtRdData = regRd ? nxtRd : rdZero;

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Mask register
  always_ff @(posedge refClk) begin
    if (rst) begin
      maskFf <= MASK_W'(i2cam_pkg::MASK_RST);
    end else if (wrMask) begin
      maskFf <= regWrData[MASK_W-1:0];
    end
  end

  // Own slave address
  always_ff @(posedge refClk) begin
    if (rst) begin
      ownFf <= MASK_W'(i2cam_pkg::OWN_RST);
    end else if (wrOwn) begin
      ownFf <= regWrData[MASK_W-1:0];
    end
  end

  // Mode control
  always_ff @(posedge refClk) begin
    if (rst) begin
      ctrlFf <= i2cam_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrlFf <= regWrData[i2cam_pkg::CTRL_W-1:0];
    end
  end

  // Compare result, one cycle after the request
  always_ff @(posedge refClk) begin
    if (rst) begin
      addrMatch <= 1'b0;
      matchValid <= 1'b0;
    end else begin
      addrMatch <= nxtMatch;
      matchValid <= addrValid;
    end
  end

  // Sticky match status
  always_ff @(posedge refClk) begin
    if (rst) begin
      matchStickyFf <= 1'b0;
    end else begin
      matchStickyFf <= nxtSticky;
    end
  end

  // Read data, registered so the output comes from a flip-flop
  always_ff @(posedge refClk) begin
    if (rst) begin
      regRdData <= rdZero;
    end else begin
      regRdData <= nxtRdData;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Steps of a mask write followed by its readback
  sequence s_mask_write;
    wrMask;
  endsequence

  sequence s_mask_read;
    regRd && selMask && !regWr;
  endsequence

  // No match while slave mode is off
  property p_slave_only;
    @(posedge refClk) disable iff (rst) !slaveMode |=> !addrMatch;
  endproperty
  a_slave_only: assert property (p_slave_only) else $error("match outside slave");

  // Equal once masked bits are forced high on both sides
  property p_ignore;
    @(posedge refClk) disable iff (rst)
      addrValid && slaveMode && tenBit && ((rxAddr | maskFf) == (ownFf | maskFf))
      |=> addrMatch;
  endproperty
  a_ignore: assert property (p_ignore) else $error("masked address missed");

  // Any unmasked difference in ten-bit mode refuses the match
  property p_exact;
    @(posedge refClk) disable iff (rst)
      addrValid && tenBit && ((rxAddr | maskFf) != (ownFf | maskFf)) |=> !addrMatch;
  endproperty
  a_exact: assert property (p_exact) else $error("unmasked mismatch matched");

  // Seven-bit mode never looks at the top three address bits
  property p_seven;
    @(posedge refClk) disable iff (rst)
      addrValid && slaveMode && !tenBit
      && (((rxAddr ^ ownFf) & ~maskFf & widthSeven) == '0)
      |=> addrMatch;
  endproperty
  a_seven: assert property (p_seven) else $error("seven-bit address missed");

  // Unimplemented upper bits of the mask read zero
  property p_upper;
    @(posedge refClk) disable iff (rst)
      regRd && selMask |=> regRdData[REG_W-1:MASK_W] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("mask upper bits nonzero");

  // Written mask bits come back in the same positions
  property p_wr_rd;
    @(posedge refClk) disable iff (rst)
      s_mask_write ##1 s_mask_read
      |=> regRdData[MASK_W-1:0] == $past(regWrData[MASK_W-1:0], 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("mask readback wrong");

  // Mask cleared by reset
  property p_reset;
    @(posedge refClk) rst |=> maskFf == MASK_W'(i2cam_pkg::MASK_RST);
  endproperty
  a_reset: assert property (p_reset) else $error("mask not cleared");

  // Every request gets exactly one answer cycle
  property p_valid;
    @(posedge refClk) disable iff (rst) addrValid |=> matchValid;
  endproperty
  a_valid: assert property (p_valid) else $error("compare answer missing");

  // Hit and clear together leave the flag set
  property p_sticky;
    @(posedge refClk) disable iff (rst) nxtMatch |=> matchStickyFf;
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky match lost");

  // Read data bus idles at zero
  property p_idle_rd;
    @(posedge refClk) disable iff (rst) !regRd |=> regRdData == '0;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data not idle");

  // ----------------------------------------
  // Limitations
  // ----------------------------------------
  // The compare expects rxAddr already settled in the refClk domain;
  // bit-level bus sampling and start or stop detection sit upstream.
  // Status has one bit only; software clears it with any write, unless a hit lands in the same cycle.
  // Mask writes take effect on the next compare, never mid-request.
  // Seven-bit mode keeps the upper mask bits stored but unused,
  // so a later switch to ten-bit mode honours them again.
  // Reading an unmapped index is harmless and returns zero.
  // Back to back requests are fine: every stage is one cycle deep.
  // A request in the reset release cycle is taken normally.
  // The own address resets to zero, matching nothing sensible,
  // so software must program it before enabling slave mode.
  // The mask resets to zero: every address bit within the compared width is compared.
  // Control resets to zero: slave mode off, seven-bit mode.
  // No interrupt leaves this block; status is polled.
  // No clock enable: compare, status and read flip-flops update every edge; mask, own and control load only on writes.
  // Widths follow the parameters; defaults give ten address bits.
  // Changing MASK_W beyond the bus width is not supported.
  // ADDR_W must hold every register offset used above.
  // The read answer always stands for exactly one cycle.
  // Compare answers also stand one cycle only.
  // Nothing here drives a pin directly.
  // ----------------------------------------
endmodule
`default_nettype wire

// ---- verif/i2cam_master_model.sv ----
`default_nettype none
// Stand-in for the bus master: presents one address a cycle after go
module i2cam_master_model (
  input wire logic refClk,
  input wire logic rst,
  input wire logic go,
  input wire logic [9:0] addr,
  output logic addrValid,
  output logic [9:0] rxAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle address toggles so a stale value is never mistaken for a request
  always_ff @(posedge refClk) begin
    addrValid <= go & !rst;
    rxAddr <= (go & !rst) ? addr : ~rxAddr;
    if (rst)
      rxAddr <= 10'h155;
  end
endmodule
`default_nettype wire

// ---- verif/i2cam_tb.sv ----
`default_nettype none
module i2cam_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic refClk = 0, rst = 1, regWr = 0, regRd = 0, go = 0, addrValid, addrMatch, matchValid;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [9:0] addr = 10'h000, rxAddr, own = 10'h2a5, msk, a;
  logic rdPend_ff = 0;
  logic [15:0] rdQ[$];
  logic mQ[$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 88, nSent = 0, nSeen = 0;
  localparam int CYCLE_LIMIT = 2000;
  // Expected match from the rules: slave mode and every care bit equal
  function automatic logic expMatch(input logic [9:0] ad, m, input logic slave, ten);
    logic [9:0] width;
    width = ten ? i2cam_pkg::WIDTH_TEN : i2cam_pkg::WIDTH_SEVEN;
    expMatch = slave && (((ad ^ own) & ~m & width) == 10'h000);
  endfunction
  always #5 refClk = ~refClk;
  i2cam_core i2cam_core_i (.refClk(refClk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .addrValid(addrValid), .rxAddr(rxAddr), .addrMatch(addrMatch), .matchValid(matchValid));
  i2cam_master_model i2cam_master_model_i (.refClk(refClk), .rst(rst), .go(go),
    .addr(addr), .addrValid(addrValid), .rxAddr(rxAddr));
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic checkRead(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: read got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkMatch(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: match got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic checkCount(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: count got %0d expected %0d", $time, got, exp);
    end
  endtask
  // One bus cycle plus an optional address request; expectations queued
  task automatic step(input logic w, r, input logic [3:0] ra, input logic [15:0] d, rx,
                      input logic g, input logic [9:0] ad, input logic mx);
    regWr <= w;
    regRd <= r;
    regAddr <= ra;
    regWrData <= d;
    go <= g;
    addr <= ad;
    if (r)
      rdQ.push_back(rx);
    if (g) begin
      mQ.push_back(mx);
      nSent++;
    end
    @(posedge refClk);
  endtask
  // Watcher: results land one cycle after their request, oldest note first
  always @(posedge refClk) begin
    rdPend_ff <= regRd;
    cyc++;
    if (cyc > CYCLE_LIMIT) begin
      n_mismatch++;
      complete_run();
    end
    if (rdPend_ff)
      checkRead(regRdData, rdQ.pop_front());
    else if (!rst)
      checkRead(regRdData, i2cam_pkg::READ_ZERO);
    if (matchValid === 1'b1) begin
      nSeen++;
      checkMatch(addrMatch, mQ.pop_front());
    end
  end
  initial begin
    repeat (20) @(posedge refClk);
    rst <= 0;
    step(0, 1, i2cam_pkg::OFS_MASK, 0, 16'h0000, 0, 0, 0);
    step(1, 0, i2cam_pkg::OFS_MASK, 16'hffff, 0, 0, 0, 0);
    step(0, 1, i2cam_pkg::OFS_MASK, 0, 16'h03ff, 0, 0, 0);
    step(1, 0, i2cam_pkg::OFS_OWN, {6'h0, own}, 0, 1, own, 0);
    step(1, 0, i2cam_pkg::OFS_CTRL, 16'h0003, 0, 0, 0, 0);
    // Flip one address bit per pass in the first 30 passes so each mask position is judged alone; the last 10 add random bits
    for (int i = 0; i < 40; i++) begin
      msk = 10'($random(seed));
      a = own ^ (10'h001 << (i % 10)) ^ (i > 29 ? 10'($random(seed)) : 10'h000);
      step(1, 0, i2cam_pkg::OFS_MASK, {6'h0, msk}, 0, 0, 0, 0);
      step(0, 0, 4'h0, 0, 0, 1, a, expMatch(a, msk, 1, 1));
    end
    // Seven-bit mode: top three address bits drop out of the compare
    step(1, 0, i2cam_pkg::OFS_CTRL, 16'h0001, 0, 0, 0, 0);
    step(1, 0, i2cam_pkg::OFS_MASK, 16'h0000, 0, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 1, own ^ 10'h380, expMatch(own ^ 10'h380, 0, 1, 0));
    step(0, 0, 4'h0, 0, 0, 1, own ^ 10'h040, expMatch(own ^ 10'h040, 0, 1, 0));
    // Status clear, then a hit and a clear in one cycle: the hit wins
    step(1, 0, i2cam_pkg::OFS_STAT, 0, 0, 0, 0, 0);
    step(0, 1, i2cam_pkg::OFS_STAT, 0, 16'h0000, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 1, own, expMatch(own, 0, 1, 0));
    step(1, 0, i2cam_pkg::OFS_STAT, 0, 0, 0, 0, 0);
    step(0, 1, i2cam_pkg::OFS_STAT, 0, 16'h0001, 0, 0, 0);
    // Mid-run reset must clear a written mask and the mode
    step(1, 0, i2cam_pkg::OFS_MASK, 16'h0155, 0, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 0, 0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge refClk);
    rst <= 1'b0;
    step(0, 1, i2cam_pkg::OFS_MASK, 0, 16'h0000, 0, 0, 0);
    step(0, 1, i2cam_pkg::OFS_CTRL, 0, 16'h0000, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge refClk);
    checkCount(nSeen, nSent);
    checkCount(rdQ.size() + mQ.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
